// *** crossbar_regs.svh ***
// Register indices, field positions, reset values and signal codes
`ifndef CROSSBAR_REGS_SVH
`define CROSSBAR_REGS_SVH

// ----------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------
`define IDX_ROUTE_A 8'hE1
`define IDX_ROUTE_B 8'hE2
`define IDX_GLOBAL 8'hE3
`define IDX_STATUS 8'hE4
`define RST_ROUTE 8'h00
`define RST_GLOBAL 1'h0

// ----------------------------------------------------------
// Field positions
// ----------------------------------------------------------
`define FA_CP0 7
`define FA_ECI 6
`define FA_CEX_HI 5
`define FA_CEX_LO 3
`define FA_UART 2
`define FA_SPI 1
`define FA_SMB 0
`define FB_CLKOUT 7
`define FB_T2CAP 6
`define FB_T2 5
`define FB_IRQ1 4
`define FB_T1 3
`define FB_IRQ0 2
`define FB_T0 1
`define FB_CP1 0
`define FG_ENABLE 6
`define FS_OVERFLOW 8
`define CEX_MAX 3'h5

// ----------------------------------------------------------
// Per-pin function codes, in priority order
// ----------------------------------------------------------
`define SIG_NONE 5'h00
`define SIG_TX0 5'h01
`define SIG_RX0 5'h02
`define SIG_SCK 5'h03
`define SIG_MISO 5'h04
`define SIG_MOSI 5'h05
`define SIG_NSS 5'h06
`define SIG_SDA 5'h07
`define SIG_SCL 5'h08
`define SIG_CMP0 5'h09
`define SIG_ECI 5'h0E
`define SIG_CP0 5'h0F
`define SIG_CP1 5'h10
`define SIG_T0 5'h11
`define SIG_IRQ0 5'h12
`define SIG_T1 5'h13
`define SIG_IRQ1 5'h14
`define SIG_T2 5'h15
`define SIG_T2CAP 5'h16
`define SIG_CLKOUT 5'h17
`define NUM_SIG 23
`define NUM_PINS 32
`endif

// *** crossbar_pkg.sv ***
// Types shared by the crossbar modules
package crossbar_pkg;
  typedef logic [4:0] pin_func_t;
  typedef logic [7:0] route_reg_t;
  typedef logic [22:0] route_req_t;
endpackage

// *** route_req_if.sv ***
// Request vector passed from the decoder to the pin allocator
`timescale 1ns/1ns
interface route_req_if;
  import crossbar_pkg::*;
  // Bit k requests a pin for function code k+1
  route_req_t req;
  modport src (output req);
  modport dst (input req);
endinterface

// *** route_req_decode.sv ***
// Turns the routing registers into one request bit per function
`timescale 1ns/1ns
`include "crossbar_regs.svh"
module route_req_decode
  import crossbar_pkg::*;
(
  // Register contents
  input wire route_reg_t i_route_a,
  input wire route_reg_t i_route_b,
  input wire logic i_global_en,
  // Requests to the allocator
  route_req_if.src rq
);
  // ----------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------
  logic [2:0] cex_n;

  // Each enable bit maps onto the request of its signal(s)
  always_comb
  begin
    cex_n = i_route_a[`FA_CEX_HI:`FA_CEX_LO];
    // Reserved codes route nothing, so software sees no surprise
    if (cex_n > `CEX_MAX)
    begin
      cex_n = 3'h0;
    end
    rq.req = '0;
    rq.req[`SIG_TX0-1] = i_route_a[`FA_UART];
    rq.req[`SIG_RX0-1] = i_route_a[`FA_UART];
    for (int s = `SIG_SCK - 1; s < `SIG_SDA - 1; s++)
    begin
      rq.req[s] = i_route_a[`FA_SPI];
    end
    rq.req[`SIG_SDA-1] = i_route_a[`FA_SMB];
    rq.req[`SIG_SCL-1] = i_route_a[`FA_SMB];
    for (int k = 0; k < 5; k++)
    begin
      rq.req[`SIG_CMP0-1+k] = (k < int'(cex_n));
    end
    rq.req[`SIG_ECI-1] = i_route_a[`FA_ECI];
    rq.req[`SIG_CP0-1] = i_route_a[`FA_CP0];
    rq.req[`SIG_CP1-1] = i_route_b[`FB_CP1];
    rq.req[`SIG_T0-1] = i_route_b[`FB_T0];
    rq.req[`SIG_IRQ0-1] = i_route_b[`FB_IRQ0];
    rq.req[`SIG_T1-1] = i_route_b[`FB_T1];
    rq.req[`SIG_IRQ1-1] = i_route_b[`FB_IRQ1];
    rq.req[`SIG_T2-1] = i_route_b[`FB_T2];
    rq.req[`SIG_T2CAP-1] = i_route_b[`FB_T2CAP];
    rq.req[`SIG_CLKOUT-1] = i_route_b[`FB_CLKOUT];
    // Disabled crossbar hands out no pins at all
    if (!i_global_en)
    begin
      rq.req = '0;
    end
  end
endmodule

// *** pin_alloc.sv ***
// Hands out port pins to requested functions in priority order
`timescale 1ns/1ns
`include "crossbar_regs.svh"
module pin_alloc
  import crossbar_pkg::*;
#(
  parameter int NUM_PINS = `NUM_PINS
)
(
  // Requests and pins that the crossbar must pass over
  route_req_if.dst rq,
  input wire logic [NUM_PINS-1:0] i_pin_skip,
  // Resulting map
  output pin_func_t [NUM_PINS-1:0] o_pin_func,
  output logic [5:0] o_routed_cnt,
  output logic o_overflow
);
  // ----------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------
  if (NUM_PINS < 2 || NUM_PINS > 32)
  begin : g_bad_pins
    $error("pin_alloc: NUM_PINS must be 2 to 32");
  end

  // ----------------------------------------------------------
  // Allocation by rank
  // ----------------------------------------------------------
  pin_func_t [NUM_PINS-1:0] by_rank;
  logic [NUM_PINS-1:0] free_pin;

  // The n-th requested function lands on the n-th free pin;
  // functions beyond the last free pin get no pin at all
  always_comb
  begin
    int r;
    int f;
    r = 0;
    f = 0;
    by_rank = '0;
    o_pin_func = '0;
    free_pin = ~i_pin_skip;
    // UART has fixed pins, even if they are marked skipped
    if (rq.req[`SIG_TX0-1])
    begin
      o_pin_func[0] = `SIG_TX0;
      o_pin_func[1] = `SIG_RX0;
      free_pin[1:0] = 2'h0;
    end
    for (int k = `SIG_SCK - 1; k < `NUM_SIG; k++)
    begin
      if (rq.req[k])
      begin
        if (r < NUM_PINS)
        begin
          by_rank[r] = pin_func_t'(k + 1);
        end
        r++;
      end
    end
    for (int i = 0; i < NUM_PINS; i++)
    begin
      if (free_pin[i])
      begin
        if (f < r)
        begin
          o_pin_func[i] = by_rank[f];
        end
        f++;
      end
    end
    o_overflow = (r > f);
    o_routed_cnt = 6'((r > f) ? f : r) +
      (rq.req[`SIG_TX0-1] ? 6'h2 : 6'h0);
  end
endmodule

// *** crossbar_route_top.sv ***
// Port crossbar routing enables with APB register access
`timescale 1ns/1ns
`include "crossbar_regs.svh"
module crossbar_route_top
  import crossbar_pkg::*;
#(
  parameter int NUM_PINS = `NUM_PINS
)
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Pins that other port logic has claimed
  input wire logic [NUM_PINS-1:0] i_pin_skip,
  // Pin map
  output pin_func_t [NUM_PINS-1:0] o_pin_func,
  output logic [NUM_PINS-1:0] o_pin_routed,
  output logic [NUM_PINS-1:0] o_pin_input_forced
);
  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------

  // Word address match for a register index
  function automatic logic addr_hit(input logic [11:0] a,
                                    input logic [7:0] idx);
    addr_hit = (a == {2'h0, idx, 2'h0});
  endfunction

  // True if any pin of the map carries the given function
  function automatic logic has_code(
    input pin_func_t [NUM_PINS-1:0] m, input pin_func_t c);
    has_code = 1'b0;
    for (int i = 0; i < NUM_PINS; i++)
    begin
      if (m[i] == c)
      begin
        has_code = 1'b1;
      end
    end
  endfunction

  // ----------------------------------------------------------
  // Register state
  // ----------------------------------------------------------
  route_reg_t route_a_ff; // First routing register
  route_reg_t route_b_ff; // Second routing register
  logic global_ff; // Crossbar master enable
  route_reg_t nxt_route_a;
  route_reg_t nxt_route_b;
  logic nxt_global;
  logic pready_ff; // One wait state per access
  logic nxt_pready;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic pslverr_ff;
  logic nxt_pslverr;
  logic access; // Access phase in progress
  logic take; // Edge at which the transfer completes
  logic hit_a;
  logic hit_b;
  logic hit_g;
  logic hit_s;

  // ----------------------------------------------------------
  // Allocator results and output flops
  // ----------------------------------------------------------
  pin_func_t [NUM_PINS-1:0] alloc_func;
  logic [5:0] alloc_cnt;
  logic alloc_ovf;
  pin_func_t [NUM_PINS-1:0] pin_func_ff;
  logic [NUM_PINS-1:0] routed_ff;
  logic [NUM_PINS-1:0] forced_ff;
  logic [5:0] cnt_ff; // Pins in use, for the status word
  logic ovf_ff; // Some request found no free pin
  logic [NUM_PINS-1:0] nxt_routed;

  route_req_if rq_bus ();

  // ----------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------
  route_req_decode u_decode (
    .i_route_a (route_a_ff),
    .i_route_b (route_b_ff),
    .i_global_en (global_ff),
    .rq (rq_bus.src)
  );

  pin_alloc #(
    .NUM_PINS (NUM_PINS)
  ) u_alloc (
    .rq (rq_bus.dst),
    .i_pin_skip (i_pin_skip),
    .o_pin_func (alloc_func),
    .o_routed_cnt (alloc_cnt),
    .o_overflow (alloc_ovf)
  );

  // ----------------------------------------------------------
  // APB decode and register next state
  // ----------------------------------------------------------

  // Writes land only at the edge that completes the transfer;
  // the answer is always one wait state so outputs stay flopped
  always_comb
  begin
    access = i_psel & i_penable;
    take = access & pready_ff;
    hit_a = addr_hit(i_paddr, `IDX_ROUTE_A);
    hit_b = addr_hit(i_paddr, `IDX_ROUTE_B);
    hit_g = addr_hit(i_paddr, `IDX_GLOBAL);
    hit_s = addr_hit(i_paddr, `IDX_STATUS);
    nxt_route_a = route_a_ff;
    nxt_route_b = route_b_ff;
    nxt_global = global_ff;
    nxt_pready = access & ~pready_ff;
    nxt_prdata = prdata_ff;
    nxt_pslverr = 1'b0;
    // Writes go through byte lane 0 only
    if (take && i_pwrite && i_pstrb[0])
    begin
      if (hit_a)
      begin
        nxt_route_a = i_pwdata[7:0];
      end
      if (hit_b)
      begin
        nxt_route_b = i_pwdata[7:0];
      end
      if (hit_g)
      begin
        nxt_global = i_pwdata[`FG_ENABLE];
      end
    end
    // Answer data and error are set up with pready
    if (nxt_pready)
    begin
      nxt_prdata = 32'h0000_0000;
      if (hit_a)
      begin
        nxt_prdata[7:0] = route_a_ff;
      end
      else if (hit_b)
      begin
        nxt_prdata[7:0] = route_b_ff;
      end
      else if (hit_g)
      begin
        nxt_prdata[`FG_ENABLE] = global_ff;
      end
      else if (hit_s)
      begin
        nxt_prdata[5:0] = cnt_ff;
        nxt_prdata[`FS_OVERFLOW] = ovf_ff;
      end
      else
      begin
        // Unmapped word answers with an error and zero data
        nxt_pslverr = 1'b1;
      end
      // Status is read-only; writing it is an error
      if (i_pwrite && hit_s)
      begin
        nxt_pslverr = 1'b1;
      end
    end
  end

  // Register the bus side
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      route_a_ff <= `RST_ROUTE;
      route_b_ff <= `RST_ROUTE;
      global_ff <= `RST_GLOBAL;
      pready_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      route_a_ff <= nxt_route_a;
      route_b_ff <= nxt_route_b;
      global_ff <= nxt_global;
      pready_ff <= nxt_pready;
      prdata_ff <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // ----------------------------------------------------------
  // Pin map next state
  // ----------------------------------------------------------

  // A pin is routed when it carries any function code
  always_comb
  begin
    for (int i = 0; i < NUM_PINS; i++)
    begin
      nxt_routed[i] = (alloc_func[i] != `SIG_NONE);
    end
  end

  // Map is flopped so pin muxes never see decode glitches
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      pin_func_ff <= '0;
      routed_ff <= '0;
      forced_ff <= '1;
      cnt_ff <= 6'h00;
      ovf_ff <= 1'b0;
    end
    else
    begin
      pin_func_ff <= alloc_func;
      routed_ff <= nxt_routed;
      forced_ff <= {NUM_PINS{~global_ff}};
      cnt_ff <= alloc_cnt;
      ovf_ff <= alloc_ovf;
    end
  end

  assign o_prdata = prdata_ff;
  assign o_pready = pready_ff;
  assign o_pslverr = pslverr_ff;
  assign o_pin_func = pin_func_ff;
  assign o_pin_routed = routed_ff;
  assign o_pin_input_forced = forced_ff;

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  xbar_off_forces_a: assert property (
    !global_ff |=> (&o_pin_input_forced) && !(|o_pin_routed))
    else $error("disabled crossbar still routes a pin");

  uart_fixed_pins_a: assert property (
    global_ff && route_a_ff[`FA_UART] |=>
      o_pin_func[0] == `SIG_TX0 && o_pin_func[1] == `SIG_RX0)
    else $error("UART not on the first two pins");

  cp0_gate_a: assert property (
    !route_a_ff[`FA_CP0] |=> !has_code(o_pin_func, `SIG_CP0))
    else $error("comparator zero routed while disabled");

  spi_first_a: assert property (
    global_ff && route_a_ff[`FA_SPI] && !route_a_ff[`FA_UART]
      && i_pin_skip[3:0] == 4'h0 |=>
      o_pin_func[0] == `SIG_SCK && o_pin_func[3] == `SIG_NSS)
    else $error("SPI not on first four free pins");

  smbus_gate_a: assert property (
    !route_a_ff[`FA_SMB] |=> !has_code(o_pin_func, `SIG_SDA)
      && !has_code(o_pin_func, `SIG_SCL))
    else $error("SMBus routed while disabled");

  cex_reserved_a: assert property (
    route_a_ff[`FA_CEX_HI:`FA_CEX_LO] > `CEX_MAX |=>
      !has_code(o_pin_func, `SIG_CMP0))
    else $error("reserved compare code routed an output");

  clkout_gate_a: assert property (
    !route_b_ff[`FB_CLKOUT] |=> !has_code(o_pin_func, `SIG_CLKOUT))
    else $error("system clock output routed while disabled");

  irq0_route_a: assert property (
    global_ff && route_b_ff == 8'h04 && route_a_ff == 8'h00
      && !i_pin_skip[0] |=> o_pin_func[0] == `SIG_IRQ0)
    else $error("interrupt zero not on first free pin");

  skip_honoured_a: assert property (
    global_ff && !route_a_ff[`FA_UART] && i_pin_skip[0] |=>
      !o_pin_routed[0])
    else $error("skipped pin was given a function");

  apb_wait_a: assert property (
    i_psel && i_penable && !o_pready |=> o_pready ##1 !o_pready)
    else $error("APB answer not after exactly one wait state");

  route_write_a: assert property (
    i_psel && i_penable && o_pready && i_pwrite && i_pstrb[0]
      && i_paddr == {2'h0, `IDX_ROUTE_B, 2'h0} |=>
      route_b_ff[`FB_CP1] == $past(i_pwdata[`FB_CP1]))
    else $error("routing register write was lost");

  uart_spi_cov: cover property (
    global_ff && route_a_ff[`FA_UART] && route_a_ff[`FA_SPI]);
  overflow_cov: cover property (ovf_ff && global_ff);
  err_answer_cov: cover property (o_pready && o_pslverr);
endmodule

// *** port_pin_claimer.sv ***
// Model of the port logic that claims pins away from the crossbar
`timescale 1ns/1ns
module port_pin_claimer
(
  // Claims made by the memory interface and the analog inputs
  input wire logic i_mem_low_en,
  input wire logic [7:0] i_p1_digital,
  // Pins that the crossbar must pass over
  output logic [31:0] o_pin_skip
);
  // ----------------------------------------
  // Claim map
  // ----------------------------------------
  // Memory interface owns port 0 pins 5..7; analog port 1 pins are skipped
  // Kept combinational so the only latency seen is the crossbar's own
  assign o_pin_skip = {16'h0000, ~i_p1_digital,
                       i_mem_low_en ? 8'hE0 : 8'h00};
endmodule

// *** port_crossbar_route_enables_test.sv ***
// Self-checking bench for the crossbar routing enables
`timescale 1ns/1ns
module port_crossbar_route_enables_test;
  import crossbar_pkg::*;
  // ----------------------------------------
  // Addresses and bench state
  // ----------------------------------------
  localparam logic [11:0] ADDR_A = 12'h384; // First routing register
  localparam logic [11:0] ADDR_B = 12'h388; // Second routing register
  localparam logic [11:0] ADDR_G = 12'h38C; // Global enable register
  localparam logic [11:0] ADDR_S = 12'h390; // Read-only status
  logic i_clk, i_resetn, psel, penable, pwrite, mem_low, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [31:0] exp_v; // Expected value worked out per step
  logic [3:0] pstrb;
  logic pready, pslverr;
  logic [7:0] p1_dig;
  logic [31:0] pin_skip, routed, forced;
  pin_func_t [31:0] pin_func;
  int n_errors = 0;
  int num_checks = 0;
  // ----------------------------------------
  // Design, and the port logic beside it
  // ----------------------------------------
  crossbar_route_top #(.NUM_PINS(32)) i_dut (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_pin_skip(pin_skip),
    .o_pin_func(pin_func), .o_pin_routed(routed),
    .o_pin_input_forced(forced));
  port_pin_claimer i_claim (.i_mem_low_en(mem_low),
    .i_p1_digital(p1_dig), .o_pin_skip(pin_skip));
  // ----------------------------------------
  // Clock
  // ----------------------------------------
  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  // ----------------------------------------
  // Reporting
  // ----------------------------------------
  task check(input string name, input logic [31:0] seen,
             input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ----------------------------------------
  // APB master: holds the request until pready is sampled high
  // ----------------------------------------
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
           input logic [3:0] st);
    int n;
    n = 0;
    @(posedge i_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    pstrb <= st;
    @(posedge i_clk);
    penable <= 1'b1;
    // Bounded wait; the slave decides how long the access lasts
    do @(posedge i_clk); while (pready !== 1'b1 && ++n < 40);
    if (n >= 40)
      check("pready timeout", 1'b0, 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask
  task rd(input string name, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, 4'hF);
    check(name, rdat, exp);
  endtask
  // Pin map trails the registers by one clock; let it land
  task settle;
    repeat (2) @(posedge i_clk);
    #1;
  endtask
  // One second-register bit alone must land on the first pin
  task b_alone(input int b, input logic [31:0] code);
    wr(ADDR_B, 32'h0000_0001 << b);
    settle;
    check("b pin0", pin_func[0], code);
    check("b routed", routed, 32'h0000_0001);
  endtask
  // ----------------------------------------
  // Watchdog: the tests need a few thousand cycles at most
  // ----------------------------------------
  initial
  begin
    #(20 * 20000);
    n_errors++;
    test_done;
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    i_resetn = 1'b0;
    {psel, penable, pwrite, mem_low} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    p1_dig = 8'hFF;
    repeat (3) @(posedge i_clk);
    i_resetn <= 1'b1;
    // Reset values, readback and refused accesses
    #1;
    check("forced at reset", forced, 32'hFFFF_FFFF);
    rd("route a reset", ADDR_A, 32'h0000_0000);
    rd("route b reset", ADDR_B, 32'h0000_0000);
    wr(ADDR_A, 32'hFFFF_FFA5);
    rd("route a readback", ADDR_A, 32'h0000_00A5);
    apb(1'b1, ADDR_B, 32'h0000_005A, 4'h0);
    rd("strobe-less write", ADDR_B, 32'h0000_0000);
    apb(1'b0, 12'h3A0, 32'h0000_0000, 4'hF);
    check("unmapped error", rerr, 1'b1);
    check("unmapped data", rdat, 32'h0000_0000);
    wr(ADDR_S, 32'h0000_0000);
    check("status write error", rerr, 1'b1);
    settle;
    check("nothing while disabled", routed, 32'h0000_0000);
    $display("test registers done");
    // Each second-register bit alone lands on pin 0 with its own code
    wr(ADDR_A, 32'h0000_0000);
    wr(ADDR_G, 32'h0000_0040);
    rd("global readback", ADDR_G, 32'h0000_0040);
    b_alone(0, 32'h0000_0010);
    b_alone(1, 32'h0000_0011);
    b_alone(2, 32'h0000_0012);
    b_alone(3, 32'h0000_0013);
    b_alone(4, 32'h0000_0014);
    b_alone(5, 32'h0000_0015);
    b_alone(6, 32'h0000_0016);
    b_alone(7, 32'h0000_0017);
    check("not forced", forced, 32'h0000_0000);
    wr(ADDR_B, 32'h0000_0000);
    $display("test second register done");
    // First-register single enables
    wr(ADDR_A, 32'h0000_0080);
    settle;
    check("comparator zero", pin_func[0], 5'h0F);
    wr(ADDR_A, 32'h0000_0040);
    settle;
    check("array count input", pin_func[0], 5'h0E);
    check("count routed", routed, 32'h0000_0001);
    wr(ADDR_A, 32'h0000_0004);
    settle;
    check("uart tx", pin_func[0], 5'h01);
    check("uart rx", pin_func[1], 5'h02);
    wr(ADDR_A, 32'h0000_0002);
    settle;
    for (int p = 0; p < 4; p++)
      check("spi pins", pin_func[p], 5'h03 + p);
    check("spi routed", routed, 32'h0000_000F);
    wr(ADDR_A, 32'h0000_0001);
    settle;
    check("smbus data", pin_func[0], 5'h07);
    check("smbus clock", pin_func[1], 5'h08);
    check("smbus routed", routed, 32'h0000_0003);
    // Every compare-output code, reserved ones included
    for (int c = 0; c < 8; c++)
    begin
      wr(ADDR_A, c << 3);
      settle;
      exp_v = (c > 5) ? 32'h0000_0000 : (32'h0000_0001 << c) - 1;
      check("compare routed", routed, exp_v);
      rd("pins in use", ADDR_S, (c > 5) ? 0 : c);
    end
    $display("test first register done");
    // Priority order around claimed pins
    mem_low <= 1'b1;
    p1_dig <= 8'hFD;
    wr(ADDR_A, 32'h0000_0007);
    settle;
    check("mosi", pin_func[4], 5'h05);
    check("select past claim", pin_func[8], 5'h06);
    check("analog pin free", pin_func[9], 5'h00);
    check("data past analog", pin_func[10], 5'h07);
    check("clock next", pin_func[11], 5'h08);
    check("skip routed", routed, 32'h0000_0D1F);
    // More requests than free pins: the lowest priorities get none
    p1_dig <= 8'h00;
    wr(ADDR_A, 32'h0000_00EF);
    wr(ADDR_B, 32'h0000_00FF);
    settle;
    check("last free pin", pin_func[31], 5'h15);
    check("full routed", routed, 32'hFFFF_001F);
    rd("overflow status", ADDR_S, 32'h0000_0115);
    $display("test priority done");
    // Dropping the global enable forces every pin to input
    wr(ADDR_G, 32'h0000_0000);
    settle;
    check("forced again", forced, 32'hFFFF_FFFF);
    check("routed cleared", routed, 32'h0000_0000);
    $display("test global disable done");
    test_done;
  end
endmodule
